// file: atx_cfg.svh
// constants for the asynchronous serial transmitter
`ifndef ATX_CFG_SVH
`define ATX_CFG_SVH
`define ATX_OFS_CTRL       8'h00
`define ATX_OFS_DATA       8'h04
`define ATX_OFS_STATUS     8'h08
`define ATX_OFS_IRQ_EN     8'h0C
`define ATX_OFS_BAUD       8'h10
`define ATX_ADDR_MSB       7
`define ATX_CTRL_TX_EN     0
`define ATX_CTRL_PORT_EN   1
`define ATX_CTRL_CLOCKED   2
`define ATX_CTRL_NINE      3
`define ATX_CTRL_INVERT    4
`define ATX_CTRL_HIGH_SPD  5
`define ATX_CTRL_WIDE      6
`define ATX_CTRL_NINTH     7
`define ATX_CTRL_W         8
`define ATX_CTRL_RESET     8'h00
`define ATX_BAUD_RESET     16'h0000
`define ATX_STAT_EMPTY     0
`define ATX_STAT_SH_EMPTY  1
`define ATX_STAT_IRQ       2
`define ATX_IRQ_TX_EN      0
`define ATX_IRQ_PERIPH     1
`define ATX_IRQ_GLOBAL     2
`define ATX_IRQ_W          3
`define ATX_IRQ_RESET      3'h0
`define ATX_PRE_SLOW       6'h3F
`define ATX_PRE_MID        6'h0F
`define ATX_PRE_FAST       6'h03
`define ATX_FRAME_BITS8    4'hA
`define ATX_FRAME_BITS9    4'hB
`define ATX_FRAME_W        11
`endif

// file: atx_pkg.sv
// types for the asynchronous serial transmitter
package atx_pkg;
  typedef enum logic [0:0]
  {
    ATX_IDLE = 1'b0,
    ATX_SEND = 1'b1
  } atx_state_t;
endpackage : atx_pkg

// file: atx_baud_gen.sv
// bit period generator for the serial transmitter
`timescale 1ns/1ns
`include "atx_cfg.svh"
module atx_baud_gen
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        run,
  input  wire logic [15:0] divisor,
  input  wire logic        wide,
  input  wire logic        high,
  output logic             tick
);
  logic [5:0]  pre;
  logic [15:0] div;
  logic [5:0]  pre_limit;
  logic [15:0] div_limit;

  // period is (pre_limit+1)*(div_limit+1) system clocks
  always_comb
  begin
    unique case ({wide, high})
      2'b00:   pre_limit = `ATX_PRE_SLOW;
      2'b11:   pre_limit = `ATX_PRE_FAST;
      default: pre_limit = `ATX_PRE_MID;
    endcase
    div_limit = wide ? divisor : {8'h00, divisor[7:0]};
  end

  // counters restart when idle so each frame begins on a full period
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre <= 6'h00;
      div <= 16'h0000;
    end
    else if (!run)
    begin
      pre <= 6'h00;
      div <= 16'h0000;
    end
    else if (pre == pre_limit)
    begin
      pre <= 6'h00;
      div <= (div == div_limit) ? 16'h0000 : div + 16'h0001;
    end
    else
      pre <= pre + 6'h01;
  end

  assign tick = run && (pre == pre_limit) && (div == div_limit);
endmodule : atx_baud_gen

// file: atx_uart_tx.sv
// asynchronous serial transmitter with ahb-lite register slave
`timescale 1ns/1ns
`include "atx_cfg.svh"
module atx_uart_tx
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             tx_pin_out,
  output logic             tx_pin_oe,
  output logic             tx_irq_request
);
  logic [`ATX_CTRL_W-1:0]  ctrl;
  logic [`ATX_IRQ_W-1:0]   irq_en;
  logic [15:0]             baud_div;
  logic [7:0]              tx_holding_buffer;
  logic                    hold_full;
  logic [`ATX_FRAME_W-1:0] output_shifter;
  logic [3:0]              bits_left;
  atx_pkg::atx_state_t     state;
  logic                    tx_empty_flag;
  logic                    shifter_empty_status;
  logic                    dp_write;
  logic [`ATX_ADDR_MSB:0]  dp_addr;
  logic                    transmit_enable;
  logic                    port_enable;
  logic                    clocked_mode_select;
  logic                    nine_bit_send_enable;
  logic                    output_polarity_invert;
  logic                    ninth_send_bit;
  logic                    enabled;
  logic                    load;
  logic                    bit_tick;
  logic                    line_level;
  logic                    addr_phase;
  logic [31:0]             next_rdata;

  assign transmit_enable        = ctrl[`ATX_CTRL_TX_EN];
  assign port_enable            = ctrl[`ATX_CTRL_PORT_EN];
  assign clocked_mode_select    = ctrl[`ATX_CTRL_CLOCKED];
  assign nine_bit_send_enable   = ctrl[`ATX_CTRL_NINE];
  assign output_polarity_invert = ctrl[`ATX_CTRL_INVERT];
  assign ninth_send_bit         = ctrl[`ATX_CTRL_NINTH];

  assign enabled = transmit_enable && port_enable
                   && !clocked_mode_select;
  assign load    = enabled && hold_full
                   && (state == atx_pkg::ATX_IDLE);

  // zero wait-state slave, always okay
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addr_phase = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write <= 1'b0;
      dp_addr  <= '0;
    end
    else if (hready)
    begin
      dp_write <= addr_phase && hwrite;
      dp_addr  <= haddr[`ATX_ADDR_MSB:0];
    end
  end

  // control and configuration registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl     <= `ATX_CTRL_RESET;
      irq_en   <= `ATX_IRQ_RESET;
      baud_div <= `ATX_BAUD_RESET;
    end
    else if (dp_write)
    begin
      if (dp_addr == `ATX_OFS_CTRL)
        ctrl <= hwdata[`ATX_CTRL_W-1:0];
      if (dp_addr == `ATX_OFS_IRQ_EN)
        irq_en <= hwdata[`ATX_IRQ_W-1:0];
      if (dp_addr == `ATX_OFS_BAUD)
        baud_div <= hwdata[15:0];
    end
  end

  // holding buffer; a write in the load cycle wins and stays queued
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_holding_buffer <= 8'h00;
      hold_full         <= 1'b0;
    end
    else if (dp_write && dp_addr == `ATX_OFS_DATA)
    begin
      tx_holding_buffer <= hwdata[7:0];
      hold_full         <= 1'b1;
    end
    else if (load)
      hold_full <= 1'b0;
  end

  atx_baud_gen u_baud
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (state == atx_pkg::ATX_SEND),
    .divisor (baud_div),
    .wide    (ctrl[`ATX_CTRL_WIDE]),
    .high    (ctrl[`ATX_CTRL_HIGH_SPD]),
    .tick    (bit_tick)
  );

  // shifter: start bit in bit 0, ones fill in behind it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state          <= atx_pkg::ATX_IDLE;
      output_shifter <= '1;
      bits_left      <= 4'h0;
    end
    else if (!enabled)
    begin
      state          <= atx_pkg::ATX_IDLE;
      output_shifter <= '1;
      bits_left      <= 4'h0;
    end
    else
    begin
      unique case (state)
        atx_pkg::ATX_IDLE:
        begin
          if (load)
          begin
            state <= atx_pkg::ATX_SEND;
            // ninth slot holds the stop level in eight-bit mode
            output_shifter <= {1'b1,
                               nine_bit_send_enable ? ninth_send_bit
                                                    : 1'b1,
                               tx_holding_buffer, 1'b0};
            bits_left <= nine_bit_send_enable ? `ATX_FRAME_BITS9
                                              : `ATX_FRAME_BITS8;
          end
        end
        atx_pkg::ATX_SEND:
        begin
          if (bit_tick)
          begin
            output_shifter <= {1'b1,
                               output_shifter[`ATX_FRAME_W-1:1]};
            bits_left      <= bits_left - 4'h1;
            if (bits_left == 4'h1)
              state <= atx_pkg::ATX_IDLE;
          end
        end
      endcase
    end
  end

  // stop bit and idle both rest at mark
  assign line_level = (state == atx_pkg::ATX_SEND)
                      ? output_shifter[0] : 1'b1;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_pin_out <= 1'b1;
      tx_pin_oe  <= 1'b0;
    end
    else
    begin
      tx_pin_out <= line_level ^ output_polarity_invert;
      tx_pin_oe  <= port_enable;
    end
  end

  // status flags, registered so they settle within two cycles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_empty_flag        <= 1'b0;
      shifter_empty_status <= 1'b1;
      tx_irq_request       <= 1'b0;
    end
    else
    begin
      tx_empty_flag <= enabled && !hold_full;
      shifter_empty_status <= (state == atx_pkg::ATX_IDLE)
                              && !load;
      tx_irq_request <= enabled && !hold_full
                        && irq_en[`ATX_IRQ_TX_EN]
                        && irq_en[`ATX_IRQ_PERIPH]
                        && irq_en[`ATX_IRQ_GLOBAL];
    end
  end

  // read data prepared at the address phase, shown in the data phase
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (haddr[`ATX_ADDR_MSB:0])
      `ATX_OFS_CTRL:
        next_rdata[`ATX_CTRL_W-1:0] = ctrl;
      `ATX_OFS_STATUS:
      begin
        next_rdata[`ATX_STAT_EMPTY]    = tx_empty_flag;
        next_rdata[`ATX_STAT_SH_EMPTY] = shifter_empty_status;
        next_rdata[`ATX_STAT_IRQ]      = tx_irq_request;
      end
      `ATX_OFS_IRQ_EN:
        next_rdata[`ATX_IRQ_W-1:0] = irq_en;
      `ATX_OFS_BAUD:
        next_rdata[15:0] = baud_div;
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_phase && !hwrite)
      hrdata <= next_rdata;
  end
endmodule : atx_uart_tx

// file: atx_sva.sv
// port checker for the asynchronous serial transmitter
`timescale 1ns/1ns
module atx_sva
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        tx_pin_out,
  input wire logic        tx_pin_oe,
  input wire logic        tx_irq_request
);
  // bit-length checks assume the fast setting of four clocks per bit
  logic        wr_q;
  logic        rd_q;
  logic [7:0]  adr_q;
  logic [7:0]  ctrl;
  logic [2:0]  ien;
  logic [15:0] baud;
  logic [5:0]  quiet;
  logic [2:0]  off_cnt;
  logic        run;
  logic        port_on;
  logic        ien_all;
  assign run = ctrl[0] & ctrl[1] & !ctrl[2];
  assign port_on = ctrl[1];
  assign ien_all = &ien;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      adr_q <= 8'h00;
    end
    else
    begin
      wr_q <= hsel & hready & htrans[1] & hwrite;
      rd_q <= hsel & hready & htrans[1] & !hwrite;
      adr_q <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= 8'h00;
      ien <= 3'h0;
      baud <= 16'h0000;
    end
    else if (wr_q)
    begin
      if (adr_q == 8'h00) ctrl <= hwdata[7:0];
      if (adr_q == 8'h0C) ien <= hwdata[2:0];
      if (adr_q == 8'h10) baud <= hwdata[15:0];
    end
  end
  // a long quiet line means no frame is under way
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      quiet <= 6'h3F;
      off_cnt <= 3'h7;
    end
    else
    begin
      quiet <= $changed(tx_pin_out) ? 6'h00 : quiet + {5'h0, quiet != 6'h3F};
      off_cnt <= run ? 3'h0 : off_cnt + {2'h0, off_cnt != 3'h7};
    end
  end
  // the pin enable is registered, so it trails the control write by a cycle
  a_oe_port: assert property (tx_pin_oe == $past(port_on))
    else $error("output enable differs from port enable");
  a_irq_gated: assert property (tx_irq_request |-> $past(ien_all))
    else $error("irq request without all enables");
  a_bit_hold: assert property ($changed(tx_pin_out) && run |=>
    ($stable(tx_pin_out) || !run)[*3])
    else $error("line bit shorter than one bit period");
  a_idle_off: assert property (off_cnt > 3'h2 && $stable(ctrl[4])
    |-> tx_pin_out == !ctrl[4])
    else $error("line not at idle level while disabled");
  a_start_soon: assert property (wr_q && adr_q == 8'h04 && run
    && quiet > 6'h2F |-> ##[1:6] tx_pin_out == ctrl[4])
    else $error("no start bit after data write");
  a_data_hidden: assert property (rd_q && adr_q == 8'h04
    |-> hrdata == 32'h0000_0000)
    else $error("data register read not zero");
  a_baud_back: assert property (rd_q && adr_q == 8'h10
    |-> hrdata == {16'h0000, baud})
    else $error("baud divisor readback wrong");
  a_shifter_idle: assert property (rd_q && adr_q == 8'h08
    && off_cnt > 3'h4 |-> hrdata[1])
    else $error("shifter empty status clear while idle");
endmodule : atx_sva

// file: atx_rx_model.sv
// behavioural remote receiver watching the serial line
`timescale 1ns/1ns
module atx_rx_model
#(
  parameter int BIT_CLKS = 4
)
(
  input  wire logic  hclk,
  input  wire logic  line,
  input  wire logic  inv,
  input  wire logic  nine,
  input  wire logic  listen,
  output logic [8:0] rx_data,
  output logic       rx_bad,
  output int         rx_count
);
  logic [8:0] sh;
  initial
  begin
    rx_bad = 1'b0;
    rx_count = 0;
    rx_data = 9'h000;
    forever
    begin
      @(posedge hclk iff listen && (line ^ inv) == 1'b0);
      repeat (BIT_CLKS / 2) @(posedge hclk);
      if ((line ^ inv) !== 1'b0) rx_bad = 1'b1;
      sh = 9'h000;
      for (int i = 0; i <= (nine ? 9 : 8); i++)
      begin
        repeat (BIT_CLKS) @(posedge hclk);
        if (i < (nine ? 9 : 8)) sh[i] = line ^ inv;
        else if ((line ^ inv) !== 1'b1) rx_bad = 1'b1;
      end
      rx_data = sh;
      rx_count = rx_count + 1;
    end
  end
endmodule : atx_rx_model

// file: tb_top.sv
// top-level bench for the asynchronous serial transmitter
`timescale 1ns/1ns
module tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        tx_pin_out;
  logic        tx_pin_oe;
  logic        tx_irq_request;
  logic        inv = 1'b0;
  logic        nine = 1'b0;
  logic        listen = 1'b0;
  logic [8:0]  rx_data;
  logic        rx_bad;
  int          rx_count;
  int          nrx = 0;
  int          miscompares = 0;
  int          total_checks = 0;
  always #10 hclk = !hclk;
  atx_uart_tx DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
    .tx_irq_request(tx_irq_request));
  atx_rx_model u_rx (.hclk(hclk), .line(tx_pin_out), .inv(inv), .nine(nine),
    .listen(listen), .rx_data(rx_data), .rx_bad(rx_bad), .rx_count(rx_count));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk iff hready);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk iff hready);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0000_0000, r);
    chk(r & m, e);
  endtask : rd
  task automatic rx_chk(input logic [8:0] e);
    nrx++;
    repeat (300) if (rx_count < nrx) @(posedge hclk);
    chk({rx_count == nrx, 21'h0, rx_bad, rx_data}, {1'b1, 22'h0, e});
  endtask : rx_chk
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    test_done();
  end
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({29'h0, hresp, tx_pin_oe, tx_pin_out}, 32'h0000_0001);
    rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h04, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h08, 32'h0000_0002, 32'h0000_0002);
    $display("test reset done");
    // fast setting: wide and high-speed divisor of zero, four clocks a bit
    wr(8'h10, 32'h0000_0000);
    wr(8'h00, 32'h0000_0063);
    rd(8'h00, 32'h0000_00FF, 32'h0000_0063);
    chk({31'h0, tx_pin_oe}, 32'h0000_0001);
    rd(8'h08, 32'h0000_0007, 32'h0000_0003);
    for (int v = 0; v < 8; v++)
    begin
      wr(8'h0C, 32'(v));
      repeat (2) @(posedge hclk);
      chk({31'h0, tx_irq_request}, {31'h0, v == 7});
    end
    $display("test enables done");
    listen <= 1'b1;
    wr(8'h04, 32'h0000_00A5);
    wr(8'h04, 32'h0000_003C);
    repeat (3) @(posedge hclk);
    rd(8'h08, 32'h0000_0007, 32'h0000_0000);
    rx_chk(9'h0A5);
    rx_chk(9'h03C);
    $display("test back to back done");
    wr(8'h00, 32'h0000_00EB);
    nine <= 1'b1;
    wr(8'h04, 32'h0000_000F);
    rx_chk(9'h10F);
    wr(8'h00, 32'h0000_006B);
    wr(8'h04, 32'h0000_00F0);
    rx_chk(9'h0F0);
    $display("test nine bit done");
    // receiver deaf while the polarity flips, so the swap is no start bit
    listen <= 1'b0;
    nine <= 1'b0;
    wr(8'h00, 32'h0000_0073);
    repeat (2) @(posedge hclk);
    chk({31'h0, tx_pin_out}, 32'h0000_0000);
    inv <= 1'b1;
    listen <= 1'b1;
    wr(8'h04, 32'h0000_005A);
    rx_chk(9'h05A);
    $display("test invert done");
    listen <= 1'b0;
    wr(8'h04, 32'h0000_0000);
    wr(8'h0C, 32'h0000_0000);
    repeat (12) @(posedge hclk);
    wr(8'h00, 32'h0000_0072);
    repeat (5) @(posedge hclk);
    chk({30'h0, tx_irq_request, tx_pin_out}, 32'h0000_0000);
    rd(8'h08, 32'h0000_0002, 32'h0000_0002);
    $display("test abort done");
    // clocked mode selected: the queued character must not go out
    wr(8'h00, 32'h0000_0077);
    wr(8'h04, 32'h0000_0000);
    repeat (8) @(posedge hclk);
    chk({31'h0, tx_pin_out}, 32'h0000_0000);
    rd(8'h08, 32'h0000_0003, 32'h0000_0002);
    $display("test clocked mode done");
    test_done();
  end
endmodule : tb_top
bind atx_uart_tx atx_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hwdata(hwdata), .hrdata(hrdata), .tx_pin_out(tx_pin_out),
  .tx_pin_oe(tx_pin_oe), .tx_irq_request(tx_irq_request));
